// *** hdl/pwm_out_regs.vh ***
// Constants for the four-channel PWM output block.
// Assumes inclusion by bare name from the hdl/ directory.
`ifndef PWM_OUT_REGS_VH
`define PWM_OUT_REGS_VH

`define PWM_NUM_CH        4
`define PWM_CLK_HZ        28'hBEBC200
`define PWM_FREQ_MIN_HZ   16'h0001
`define PWM_FREQ_MAX_HZ   16'hC350
`define PWM_DUTY_FULL     14'h2710
`define PWM_DUTY_W        14
`define PWM_FREQ_W        16
`define PWM_CNT_W         28
`define PWM_CH_W          2
`define PWM_RST_FREQ      16'h0000
`define PWM_RST_DUTY      14'h0000

`endif

// *** hdl/pwm_channel.v ***
// One PWM channel: period counter with shadowed period and on-time.
// Assumes one clock domain; settings arrive as a one-cycle load pulse.
`timescale 1ns/100ps
`include "pwm_out_regs.vh"
module pwm_channel #(
    parameter CNT_W = `PWM_CNT_W
) (
    input  wire             clk_sys_in,
    input  wire             rst_in,
    input  wire             load_in,
    input  wire [CNT_W-1:0] period_in,
    input  wire [CNT_W-1:0] on_in,
    output wire             pin_sink_out
);
    reg  [CNT_W-1:0] cnt_ff;
    reg  [CNT_W-1:0] period_ff;
    reg  [CNT_W-1:0] on_ff;
    reg  [CNT_W-1:0] pend_period_ff;
    reg  [CNT_W-1:0] pend_on_ff;
    reg              pend_ff;
    reg              sink_ff;
    wire             wrap;

    // Period boundary, or idle channel waiting for its first setting
    assign wrap = (cnt_ff >= period_ff - {{(CNT_W-1){1'b0}}, 1'b1})
               || (period_ff == {CNT_W{1'b0}});

    // Counter, shadow copy taken only at the period boundary or while the channel is idle
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff         <= {CNT_W{1'b0}};
            period_ff      <= {CNT_W{1'b0}};
            on_ff          <= {CNT_W{1'b0}};
            pend_period_ff <= {CNT_W{1'b0}};
            pend_on_ff     <= {CNT_W{1'b0}};
            pend_ff        <= 1'b0;
        end else begin
            if (load_in) begin
                pend_period_ff <= period_in;
                pend_on_ff     <= on_in;
                pend_ff        <= 1'b1;
            end
            if (wrap) begin
                cnt_ff <= {CNT_W{1'b0}};
                if (pend_ff) begin
                    period_ff <= load_in ? period_in : pend_period_ff;
                    on_ff     <= load_in ? on_in : pend_on_ff;
                    pend_ff   <= 1'b0;
                end
            end else begin
                cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // On for interval a (count below on-time), then off
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sink_ff <= 1'b0;
        end else begin
            sink_ff <= (period_ff != {CNT_W{1'b0}}) && (cnt_ff < on_ff);
        end
    end

    // Active sink: on-time pulls the pin low
    assign pin_sink_out = sink_ff;
endmodule // pwm_channel

// *** hdl/pwm_outputs.v ***
// Four-channel PWM generator driving sinking outputs five to eight.
// Assumes setup commands come from logic on the same clock.
//
// Summary of operation
// - Four channels, outputs five through eight.
// - On for a, off for b, repeating.
// - Frequency spans 1 Hz to 50 kHz.
// - Duty in hundredths of a percent.
// - One command loads frequency and duty.
// - Duty may come from a memory word.
// - Duty resolution 0.01% at 50 Hz.
// - Under 0.5% frequency error at 10 kHz.
// - Under 0.01% error at low frequencies.
// - On-time sinks current, pulls pin low.
`timescale 1ns/100ps
`include "pwm_out_regs.vh"
module pwm_outputs #(
    parameter NUM_CH = `PWM_NUM_CH,
    parameter CNT_W  = `PWM_CNT_W
) (
    input  wire                    clk_sys_in,
    input  wire                    rst_in,
    input  wire                    pwm_setup_command_in,
    input  wire [`PWM_CH_W-1:0]    setup_channel_in,
    input  wire [`PWM_DUTY_W-1:0]  data_memory_word_in,
    input  wire [`PWM_FREQ_W-1:0]  setup_freq_hz_in,
    output wire                    setup_ready_out,
    output wire                    setup_error_out,
    output wire [NUM_CH-1:0]       dout_sink_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_DIV  = 2'h1;
    localparam ST_MUL  = 2'h2;
    localparam ST_LOAD = 2'h3;
    localparam DIV_LAST = CNT_W - 1;

    reg  [1:0]              state_ff;
    reg  [1:0]              nxt_state;
    reg  [`PWM_CH_W-1:0]    ch_ff;
    reg  [`PWM_DUTY_W-1:0]  duty_ff;
    reg  [`PWM_FREQ_W-1:0]  freq_ff;
    reg  [CNT_W-1:0]        rem_ff;
    reg  [CNT_W-1:0]        quo_ff;
    reg  [5:0]              bit_ff;
    reg  [CNT_W-1:0]        on_ff;
    reg                     err_ff;
    reg  [NUM_CH-1:0]       load_ch;
    wire [CNT_W+`PWM_DUTY_W-1:0] prod;
    wire [CNT_W+`PWM_DUTY_W-1:0] on_full;
    wire [CNT_W:0]          rem_try;
    wire [CNT_W-1:0]        half_freq;
    wire [31:0]             div_last;
    wire                    cmd_ok;

    // Range check on a command: frequency and duty limits
    assign cmd_ok = (setup_freq_hz_in >= `PWM_FREQ_MIN_HZ)
                 && (setup_freq_hz_in <= `PWM_FREQ_MAX_HZ)
                 && (data_memory_word_in <= `PWM_DUTY_FULL);
    assign setup_ready_out = (state_ff == ST_IDLE);
    assign setup_error_out = err_ff;

    // Restoring divider step: clocks per period = round(clk / f)
    assign rem_try = {rem_ff, quo_ff[CNT_W-1]} - {{(CNT_W-`PWM_FREQ_W+1){1'b0}}, freq_ff};
    // On-time in clocks = period * duty / 10000, exact to one clock
    assign prod = quo_ff * duty_ff;
    assign on_full = prod / `PWM_DUTY_FULL;
    // Rounding bias f/2 and first divide step, sized to the counter
    assign half_freq = {{(CNT_W-`PWM_FREQ_W+1){1'b0}}, setup_freq_hz_in[`PWM_FREQ_W-1:1]};
    assign div_last  = DIV_LAST;

    // Command sequencer
    always @* begin
        nxt_state = state_ff;
        load_ch   = {NUM_CH{1'b0}};
        case (state_ff)
            ST_IDLE: begin
                if (pwm_setup_command_in && cmd_ok) begin
                    nxt_state = ST_DIV;
                end
            end
            ST_DIV: begin
                if (bit_ff == 6'h00) begin
                    nxt_state = ST_MUL;
                end
            end
            ST_MUL: begin
                nxt_state = ST_LOAD;
            end
            ST_LOAD: begin
                load_ch[ch_ff] = 1'b1;
                nxt_state      = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Datapath for period and on-time computation
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
            ch_ff    <= {`PWM_CH_W{1'b0}};
            duty_ff  <= `PWM_RST_DUTY;
            freq_ff  <= `PWM_RST_FREQ;
            rem_ff   <= {CNT_W{1'b0}};
            quo_ff   <= {CNT_W{1'b0}};
            bit_ff   <= 6'h00;
            on_ff    <= {CNT_W{1'b0}};
            err_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            case (state_ff)
                ST_IDLE: begin
                    if (pwm_setup_command_in) begin
                        err_ff <= ~cmd_ok;
                    end
                    if (pwm_setup_command_in && cmd_ok) begin
                        ch_ff   <= setup_channel_in;
                        duty_ff <= data_memory_word_in;
                        freq_ff <= setup_freq_hz_in;
                        // Dividend pre-biased by f/2 for rounding
                        quo_ff  <= `PWM_CLK_HZ + half_freq;
                        rem_ff  <= {CNT_W{1'b0}};
                        bit_ff  <= div_last[5:0];
                    end
                end
                ST_DIV: begin
                    if (!rem_try[CNT_W]) begin
                        rem_ff <= rem_try[CNT_W-1:0];
                        quo_ff <= {quo_ff[CNT_W-2:0], 1'b1};
                    end else begin
                        rem_ff <= {rem_ff[CNT_W-2:0], quo_ff[CNT_W-1]};
                        quo_ff <= {quo_ff[CNT_W-2:0], 1'b0};
                    end
                    bit_ff <= bit_ff - 6'h01;
                end
                ST_MUL: begin
                    // 4M clocks at 50 Hz give far finer than 0.01% steps
                    on_ff <= on_full[CNT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // One channel per sinking output
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
            pwm_channel #(
                .CNT_W (CNT_W)
            ) u_ch (
                .clk_sys_in   (clk_sys_in),
                .rst_in       (rst_in),
                .load_in      (load_ch[gi]),
                .period_in    (quo_ff),
                .on_in        (on_ff),
                .pin_sink_out (dout_sink_out[gi])
            );
        end
    endgenerate
endmodule // pwm_outputs

// *** test/pwm_load_model.sv ***
// Load model: pull-up on one sinking output; times period and on time.
// Assumes the block clock samples the output.
`timescale 1ns/100ps
module pwm_load_model (
    input  wire logic   clk_in,
    input  wire logic   sink_in,
    output logic [27:0] per_out = 28'h0,
    output logic [27:0] on_out = 28'h0
);
    logic [27:0] cnt_ff = 28'h0;
    logic        pin_ff = 1'b1;
    // Pin low while sunk; pin edges give the times
    always @(posedge clk_in) begin
        pin_ff <= !sink_in;
        cnt_ff <= cnt_ff + 28'h1;
        if (pin_ff && sink_in) begin
            per_out <= cnt_ff;
            cnt_ff <= 28'h1;
        end
        if (!pin_ff && !sink_in) on_out <= cnt_ff;
    end
endmodule // pwm_load_model

// *** test/pwm_outputs_monitor.sv ***
// Checker: setup handshake, refusals, reset state.
// Assumes bind to pwm_outputs.
`timescale 1ns/100ps
module pwm_outputs_monitor #(parameter NUM_CH = 4) (
    input wire logic              clk_sys_in,
    input wire logic              rst_in,
    input wire logic              pwm_setup_command_in,
    input wire logic [13:0]       data_memory_word_in,
    input wire logic [15:0]       setup_freq_hz_in,
    input wire logic              setup_ready_out,
    input wire logic              setup_error_out,
    input wire logic [NUM_CH-1:0] dout_sink_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // Short names; taken strobe; bad frequency; bad duty
    wire r = setup_ready_out;
    wire e = setup_error_out;
    wire t = pwm_setup_command_in && r;
    wire bf = setup_freq_hz_in == 16'h0000 || setup_freq_hz_in > 16'hC350;
    wire bd = data_memory_word_in > 14'h2710;
    property p_take; t && !bf && !bd |=> !r ##30 !e; endproperty
    a_take: assert property (p_take) else $error("setup not taken");
    property p_busy; $fell(r) |-> ##29 !r ##1 r; endproperty
    a_busy: assert property (p_busy) else $error("busy length");
    property p_bad_f; t && bf |=> e && r; endproperty
    a_bad_f: assert property (p_bad_f) else $error("bad freq");
    property p_bad_d; t && bd |=> e && r; endproperty
    a_bad_d: assert property (p_bad_d) else $error("bad duty");
    property p_hold; r && !pwm_setup_command_in |=> $stable(e); endproperty
    a_hold: assert property (p_hold) else $error("error moved");
    property p_idle; r && !pwm_setup_command_in |=> r; endproperty
    a_idle: assert property (p_idle) else $error("ready lost");
    property p_rst; $fell(rst_in) |-> r && !e; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_off; $fell(rst_in) |-> (dout_sink_out == '0) [*8]; endproperty
    a_off: assert property (p_off) else $error("output on early");
endmodule // pwm_outputs_monitor
bind pwm_outputs pwm_outputs_monitor #(.NUM_CH(NUM_CH)) u_mon (
    .clk_sys_in           (clk_sys_in),
    .rst_in               (rst_in),
    .pwm_setup_command_in (pwm_setup_command_in),
    .data_memory_word_in  (data_memory_word_in),
    .setup_freq_hz_in     (setup_freq_hz_in),
    .setup_ready_out      (setup_ready_out),
    .setup_error_out      (setup_error_out),
    .dout_sink_out        (dout_sink_out)
);

// *** test/pwm_outputs_bench.sv ***
// Bench: channel timing, refused setups, full and zero duty.
// Assumes the load model times each sinking output.
`timescale 1ns/100ps
module pwm_outputs_bench;
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        cmd = 1'b0;
    logic [1:0]  ch = 2'h0;
    logic [13:0] duty = 14'h0000;
    logic [15:0] freq = 16'h0000;
    wire         rdy;
    wire         err;
    wire  [3:0]  sink;
    wire  [27:0] per [4];
    wire  [27:0] ont [4];
    int          error_cnt = 0;
    int          checked = 0;
    // Clock and the block with one load per output
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    pwm_outputs dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .pwm_setup_command_in(cmd),
        .setup_channel_in(ch), .data_memory_word_in(duty), .setup_freq_hz_in(freq),
        .setup_ready_out(rdy), .setup_error_out(err), .dout_sink_out(sink));
    for (genvar i = 0; i < 4; i++) begin : g_ld
        pwm_load_model u_ld (.clk_in(clk_sys_in), .sink_in(sink[i]), .per_out(per[i]),
            .on_out(ont[i]));
    end
    // Verdict
    task automatic close_out;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Compare
    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    // Wait for ready, then one-cycle strobe
    task automatic setup(input logic [1:0] c, input logic [13:0] d, input logic [15:0] f);
        int n;
        for (n = 0; n < 40 && rdy !== 1'b1; n++) @(negedge clk_sys_in);
        chk(28'(n == 40), 28'h0);
        if (n == 40) close_out();
        {ch, duty, freq, cmd} = {c, d, f, 1'b1};
        @(negedge clk_sys_in);
        cmd = 1'b0;
        @(negedge clk_sys_in);
    endtask
    // All four channels at once
    task automatic s_four;
        logic [15:0] fq [4] = '{16'hC350, 16'h9C40, 16'h61A8, 16'h1B58};
        logic [13:0] dq [4] = '{14'h251C, 14'h01F4, 14'h1388, 14'h09C5};
        logic [27:0] p;
        for (int c = 0; c < 4; c++) setup(2'(c), dq[c], fq[c]);
        repeat (30000) @(negedge clk_sys_in);
        for (int c = 0; c < 4; c++) begin
            p = 28'((32'h0BEBC200 + fq[c] / 2) / fq[c]);
            chk(per[c], p);
            chk(ont[c], 28'(p * dq[c] / 14'h2710));
        end
    endtask
    // Out-of-range setups refused, then cleared
    task automatic s_bad;
        logic [15:0] fq [3] = '{16'h0000, 16'hC351, 16'h0064};
        logic [13:0] dq [3] = '{14'h0064, 14'h0064, 14'h2711};
        for (int k = 0; k < 3; k++) begin
            setup(2'h3, dq[k], fq[k]);
            chk({26'h0, rdy, err}, 28'h3);
        end
        setup(2'h3, 14'h09C4, 16'hC350);
        setup(2'h3, 14'h09C4, 16'hC350);
        chk({27'h0, err}, 28'h0);
    endtask
    // Full scale stays on, zero stays off
    task automatic s_full;
        setup(2'h0, 14'h2710, 16'hC350);
        setup(2'h1, 14'h0000, 16'hC350);
        repeat (12000) @(negedge clk_sys_in);
        for (int k = 0; k < 4; k++) begin
            chk({26'h0, sink[1:0]}, 28'h1);
            repeat (1100) @(negedge clk_sys_in);
        end
    endtask
    // Reset mid-run clears error and outputs; setup right after release
    task automatic s_reset;
        setup(2'h3, 14'h0064, 16'h0000);
        rst_in = 1'b1;
        @(negedge clk_sys_in);
        chk({25'h0, rdy, err, |sink}, 28'h4);
        rst_in = 1'b0;
        setup(2'h0, 14'h2710, 16'hC350);
        repeat (40) @(negedge clk_sys_in);
        chk({24'h0, sink}, 28'h1);
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (6) @(negedge clk_sys_in);
        rst_in = 1'b0;
        s_four();
        s_bad();
        s_full();
        s_reset();
        close_out();
    end
endmodule // pwm_outputs_bench
